/* core/adcsel_regs.sv */
// Channel 0 input select, scan select and pin mode registers
// How it works
// - Sample A negative bit 1 routes input 1, else negative reference.
// - Sample A five-bit positive field picks input index equal to value.
// - Sample B positive field in bits 12..8, same mapping as A.
// - Sample B negative bit 15, same encoding as Sample A bit.
// - Channel 0 select bits 14..13 and 6..5 always read zero.
// - Second converter selects only inputs 0..15 as positive inputs.
// - Scan bit one includes its input in the scan, zero skips it.
// - High scan register covers inputs 16..31, low covers 0..15.
// - All scan bits stay writable even with fewer than 32 inputs.
// - Scanning an input without a pin converts the negative reference.
// - Pin bit one gives digital mode: read enabled, mux grounded.
// - Pin bit zero gives analog mode: read disabled, pin sampled.
// - Pin bits always read and write; missing pins ignore them.
// - Only the first converter has the high pin configuration register.
// - Both converters' low pin registers affect shared pins 0..15.
// - Low pin register maps bits to inputs 0..15, high to 16..31.
// - Converter module off forces every pin of that converter into digital mode.
// - Scan enable takes Sample A positive input from the scan.
// - Alternate sampling swaps A and B selects, else always A.
`timescale 1ns/100ps
module adcsel_regs
  import adcsel_pkg::*;
#(
  parameter int NUM_INPUTS = 32,
  parameter bit IS_SECOND  = 1'b0
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sampleDone,
  input  wire logic [15:0] peerPinDigital,
  output logic [15:0]      ownPinDigitalLow,
  output logic [4:0]       ch0PosSel,
  output logic             ch0PosToNegRef,
  output logic             ch0NegIsAn1,
  output logic             sampleIsB,
  output logic [31:0]      pinDigital
);
  if (NUM_INPUTS < 1 || NUM_INPUTS > 32) begin : g_bad_inputs
    $error("adcsel_regs: NUM_INPUTS out of range");
  end
  // Pins that really exist on this converter
  localparam int PIN_COUNT =
    (IS_SECOND && NUM_INPUTS > LOW_INPUTS) ? LOW_INPUTS : NUM_INPUTS;
  localparam logic [31:0] PIN_MASK = 32'hffffffff >> (32 - PIN_COUNT);
  localparam logic [15:0] SEL_MASK =
    IS_SECOND ? CH0_SEL_MASK_LOW : CH0_SEL_MASK;
  // ==========================================================
  // Register storage
  logic [15:0] ch0Sel_reg;
  logic [15:0] scanHi_reg;
  logic [15:0] scanLo_reg;
  logic [15:0] pinCfgHi_reg;
  logic [15:0] pinCfgLo_reg;
  logic [15:0] ctrl_reg;
  // ==========================================================
  // Write channel
  adcsel_wr_t  wrState_reg;
  logic        awHeld_reg;
  logic        wHeld_reg;
  logic [7:0]  awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;
  logic [1:0]  bresp_reg;
  logic        wrFire;
  logic        wrHit;
  assign s_axi_awready = !awHeld_reg && wrState_reg == WR_WAIT;
  assign s_axi_wready  = !wHeld_reg && wrState_reg == WR_WAIT;
  assign s_axi_bvalid  = wrState_reg == WR_RESP;
  assign s_axi_bresp   = bresp_reg;
  assign wrFire        = awHeld_reg && wHeld_reg && wrState_reg == WR_WAIT;
  always_comb begin
    case (awAddr_reg)
      OFS_CH0_SEL, OFS_SCAN_HI, OFS_SCAN_LO,
      OFS_PINCFG_LO, OFS_CTRL: wrHit = 1'b1;
      OFS_PINCFG_HI:           wrHit = !IS_SECOND;
      default:                 wrHit = 1'b0;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= s_axi_awaddr;
    end else if (wrFire) begin
      awHeld_reg <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wHeld_reg <= 1'b0;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_reg <= 1'b1;
      wData_reg <= s_axi_wdata;
      wStrb_reg <= s_axi_wstrb;
    end else if (wrFire) begin
      wHeld_reg <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrState_reg <= WR_WAIT;
      bresp_reg   <= RESP_OKAY;
    end else begin
      case (wrState_reg)
        WR_WAIT: begin
          if (wrFire) begin
            wrState_reg <= WR_RESP;
            bresp_reg   <= wrHit ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wrState_reg <= WR_WAIT;
          end
        end
        default: wrState_reg <= WR_WAIT;
      endcase
    end
  end
  // Byte-lane merge of the held write into a 16-bit register
  function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                             input logic [15:0] mask);
    logic [15:0] val;
    val[7:0]  = wStrb_reg[0] ? wData_reg[7:0] : old[7:0];
    val[15:8] = wStrb_reg[1] ? wData_reg[15:8] : old[15:8];
    return val & mask;
  endfunction
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ch0Sel_reg   <= REG_RESET;
      scanHi_reg   <= REG_RESET;
      scanLo_reg   <= REG_RESET;
      pinCfgHi_reg <= REG_RESET;
      pinCfgLo_reg <= REG_RESET;
      ctrl_reg     <= REG_RESET;
    end else if (wrFire) begin
      case (awAddr_reg)
        OFS_CH0_SEL:   ch0Sel_reg <= mergeLanes(ch0Sel_reg, SEL_MASK);
        // Scan bits are kept whole whatever the pin count
        OFS_SCAN_HI:   scanHi_reg <= mergeLanes(scanHi_reg, 16'hffff);
        OFS_SCAN_LO:   scanLo_reg <= mergeLanes(scanLo_reg, 16'hffff);
        OFS_PINCFG_HI: begin
          if (!IS_SECOND) begin
            pinCfgHi_reg <= mergeLanes(pinCfgHi_reg, 16'hffff);
          end
        end
        OFS_PINCFG_LO: pinCfgLo_reg <= mergeLanes(pinCfgLo_reg, 16'hffff);
        OFS_CTRL:      ctrl_reg <= mergeLanes(ctrl_reg, CTRL_MASK);
        default:       ;
      endcase
    end
  end
  // ==========================================================
  // Read channel
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        rvalid_reg;
  logic [15:0] rdVal;
  logic        rdHit;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  always_comb begin
    rdHit = 1'b1;
    case (s_axi_araddr)
      OFS_CH0_SEL:   rdVal = ch0Sel_reg & SEL_MASK;
      OFS_SCAN_HI:   rdVal = scanHi_reg;
      OFS_SCAN_LO:   rdVal = scanLo_reg;
      OFS_PINCFG_HI: begin
        rdVal = pinCfgHi_reg;
        rdHit = !IS_SECOND;
      end
      OFS_PINCFG_LO: rdVal = pinCfgLo_reg;
      OFS_CTRL:      rdVal = ctrl_reg;
      default: begin
        rdVal = 16'h0000;
        rdHit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rdHit ? {16'h0000, rdVal} : 32'h00000000;
      rresp_reg  <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  // ==========================================================
  // Sample sequencing and input selection
  logic        scanEn;
  logic        altEn;
  logic        modOff;
  logic [31:0] scanMask;
  logic [4:0]  scanIdx_reg;
  logic [4:0]  scanNext;
  logic [4:0]  scanFirst;
  logic        scanAny;
  logic        sampleB_reg;
  logic [4:0]  posSel_next;
  logic [4:0]  posSel_reg;
  logic        negRef_reg;
  logic        negAn1_reg;
  assign scanEn   = ctrl_reg[CTRL_SCAN_EN_BIT];
  assign altEn    = ctrl_reg[CTRL_ALT_BIT];
  assign modOff   = ctrl_reg[CTRL_MOD_OFF_BIT];
  assign scanMask = {scanHi_reg, scanLo_reg};
  adcsel_scan_next #(.N(32)) u_next (
    .scanMask (scanMask),
    .curIdx   (scanIdx_reg),
    .nextIdx  (scanNext),
    .anySet   (scanAny)
  );
  adcsel_scan_next #(.N(32)) u_first (
    .scanMask (scanMask),
    .curIdx   (5'h1f),
    .nextIdx  (scanFirst),
    .anySet   ()
  );
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sampleB_reg <= 1'b0;
    end else if (!altEn) begin
      sampleB_reg <= 1'b0;
    end else if (sampleDone) begin
      sampleB_reg <= !sampleB_reg;
    end
  end
  // A skipped input under the index is left on the next clock if any scan bit is set
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scanIdx_reg <= 5'h00;
    end else if (!scanEn || !scanAny) begin
      scanIdx_reg <= scanFirst;
    end else if (!scanMask[scanIdx_reg]) begin
      scanIdx_reg <= scanNext;
    end else if (sampleDone && !sampleB_reg) begin
      scanIdx_reg <= scanNext;
    end
  end
  always_comb begin
    if (sampleB_reg) begin
      posSel_next = ch0Sel_reg[POS_B_LSB +: POS_W];
    end else if (scanEn) begin
      posSel_next = scanIdx_reg;
    end else begin
      posSel_next = ch0Sel_reg[POS_A_LSB +: POS_W];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      posSel_reg <= 5'h00;
      negRef_reg <= 1'b0;
      negAn1_reg <= 1'b0;
    end else begin
      posSel_reg <= posSel_next;
      // Missing pins and the second converter's upper range
      negRef_reg <= int'(posSel_next) >= PIN_COUNT;
      negAn1_reg <= sampleB_reg ? ch0Sel_reg[NEG_B_BIT]
                                : ch0Sel_reg[NEG_A_BIT];
    end
  end
  assign ch0PosSel      = posSel_reg;
  assign ch0PosToNegRef = negRef_reg;
  assign ch0NegIsAn1    = negAn1_reg;
  assign sampleIsB      = sampleB_reg;
  // ==========================================================
  // Pin mode
  logic [31:0] pinDigital_reg;
  logic [31:0] cfgBits;
  assign ownPinDigitalLow = pinCfgLo_reg;
  // Either converter's low bits set a shared pin digital
  assign cfgBits = {IS_SECOND ? 16'h0000 : pinCfgHi_reg,
                    pinCfgLo_reg | peerPinDigital};
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinDigital_reg <= 32'h00000000;
    end else if (modOff) begin
      pinDigital_reg <= PIN_MASK;
    end else begin
      pinDigital_reg <= cfgBits & PIN_MASK;
    end
  end
  assign pinDigital = pinDigital_reg;
  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence seq_wr_taken;
    awHeld_reg && wHeld_reg && wrState_reg == WR_WAIT;
  endsequence
  // Response shown while both request channels are refused
  sequence seq_resp_held;
    s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endsequence
  a_unimpl_read_zero: assert property (
    (ch0Sel_reg & ~SEL_MASK) == 16'h0000)
    else $error("unimplemented select bits not zero");
  a_mod_off_digital: assert property (
    modOff |=> pinDigital == PIN_MASK)
    else $error("module off did not force digital");
  a_absent_pins_zero: assert property (
    (pinDigital & ~PIN_MASK) == 32'h00000000)
    else $error("absent pin shows digital");
  a_alt_toggles: assert property (
    altEn && sampleDone && $past(altEn) |=> sampleIsB != $past(sampleIsB))
    else $error("alternate sample did not toggle");
  a_no_alt_a: assert property (
    !altEn |=> !sampleIsB)
    else $error("sample B used without alternate mode");
  a_neg_sel_a: assert property (
    !sampleB_reg ##0 ch0Sel_reg[NEG_A_BIT] |=> ch0NegIsAn1)
    else $error("Sample A negative select not applied");
  a_scan_source: assert property (
    scanEn && !sampleB_reg |=> ch0PosSel == $past(scanIdx_reg))
    else $error("scan index not used for Sample A");
  a_nopin_negref: assert property (
    int'(ch0PosSel) >= PIN_COUNT |-> ch0PosToNegRef)
    else $error("missing pin did not convert negative reference");
  a_second_range: assert property (
    IS_SECOND && !ch0PosToNegRef |-> ch0PosSel < 5'h10)
    else $error("second converter selected an upper input");
  a_scan_writable: assert property (
    seq_wr_taken ##0 awAddr_reg == OFS_SCAN_HI ##0 wStrb_reg == 4'hf
    |=> scanHi_reg == $past(wData_reg[15:0]))
    else $error("scan high bits not all writable");
  a_high_cfg_absent: assert property (
    IS_SECOND |-> pinCfgHi_reg == 16'h0000)
    else $error("second converter holds high pin register");
  a_write_answer: assert property (
    seq_wr_taken |=> seq_resp_held)
    else $error("write response missing");
endmodule // adcsel_regs

/* core/adcsel_pkg.sv */
// Constants shared by the input select and pin configuration block
package adcsel_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CH0_SEL    = 8'h00;
  localparam logic [7:0] OFS_SCAN_HI    = 8'h04;
  localparam logic [7:0] OFS_SCAN_LO    = 8'h08;
  localparam logic [7:0] OFS_PINCFG_HI  = 8'h0c;
  localparam logic [7:0] OFS_PINCFG_LO  = 8'h10;
  localparam logic [7:0] OFS_CTRL       = 8'h14;

  // ==========================================================
  // Channel 0 select fields
  localparam int POS_A_LSB  = 0;
  localparam int POS_W      = 5;
  localparam int NEG_A_BIT  = 7;
  localparam int POS_B_LSB  = 8;
  localparam int NEG_B_BIT  = 15;
  localparam logic [15:0] CH0_SEL_MASK     = 16'h9f9f;
  localparam logic [15:0] CH0_SEL_MASK_LOW = 16'h8f8f;

  // ==========================================================
  // Control fields
  localparam int CTRL_SCAN_EN_BIT = 0;
  localparam int CTRL_ALT_BIT     = 1;
  localparam int CTRL_MOD_OFF_BIT = 2;
  localparam logic [15:0] CTRL_MASK = 16'h0007;

  // ==========================================================
  // Reset values and bus answers
  localparam logic [15:0] REG_RESET   = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int          LOW_INPUTS  = 16;

  typedef enum logic [1:0] {
    WR_WAIT = 2'b00,
    WR_RESP = 2'b01
  } adcsel_wr_t;

endpackage

/* core/adcsel_scan_next.sv */
// Finds the next included scan input after a given index, wrapping
`timescale 1ns/100ps
module adcsel_scan_next
  import adcsel_pkg::*;
#(
  parameter int N = 32
) (
  input  wire logic [N-1:0]         scanMask,
  input  wire logic [$clog2(N)-1:0] curIdx,
  output logic      [$clog2(N)-1:0] nextIdx,
  output logic                      anySet
);

  if (N < 2 || N > 32) begin : g_bad_n
    $error("adcsel_scan_next: N out of range");
  end

  // Search downward so the closest following input wins
  always_comb begin
    int idx;
    idx     = 0;
    nextIdx = curIdx;
    anySet  = |scanMask;
    for (int k = N; k >= 1; k--) begin
      idx = (int'(curIdx) + k) % N;
      if (scanMask[idx]) begin
        nextIdx = idx[$clog2(N)-1:0];
      end
    end
  end

endmodule // adcsel_scan_next

/* tb/adcsel_regs_tb.sv */
// Self-checking bench for the input select and pin mode registers
`timescale 1ns/100ps
module adcsel_regs_tb;
  import adcsel_pkg::*;

  localparam int NIN = 24;

  // ==========================================================
  // Signals
  logic        sys_clk   = 1'b0;
  logic        rst       = 1'b1;
  logic [7:0]  awAddr    = 8'h00;
  logic        awValid   = 1'b0;
  logic [31:0] wData     = 32'h00000000;
  logic [3:0]  wStrb     = 4'hf;
  logic        wValid    = 1'b0;
  logic        bReady    = 1'b0;
  logic [7:0]  arAddr    = 8'h00;
  logic        arValid   = 1'b0;
  logic        rReady    = 1'b0;
  logic        sampleDone = 1'b0;
  logic [15:0] peerPin   = 16'h0000;
  logic        awReady;
  logic        wReady;
  logic [1:0]  bResp;
  logic [1:0]  bResp2;
  logic        bValid;
  logic        arReady;
  logic [31:0] rData;
  logic [31:0] rData2;
  logic [1:0]  rResp;
  logic        rValid;
  logic [15:0] ownLow;
  logic [4:0]  ch0PosSel;
  logic [4:0]  ch0PosSel2;
  logic        ch0PosToNegRef;
  logic        ch0NegIsAn1;
  logic        sampleIsB;
  logic [31:0] pinDigital;
  logic [1:0]  lastB;
  logic [1:0]  lastB2;
  logic [31:0] lastR;
  logic [31:0] lastR2;
  logic [1:0]  lastRr;
  int          fails     = 0;
  int          numChecks = 0;

  always #10 sys_clk = ~sys_clk;

  // ==========================================================
  // Devices: first converter and a second converter on one bus
  adcsel_regs #(.NUM_INPUTS(NIN), .IS_SECOND(1'b0)) uut (
    .sys_clk(sys_clk), .rst(rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .sampleDone(sampleDone), .peerPinDigital(peerPin),
    .ownPinDigitalLow(ownLow), .ch0PosSel(ch0PosSel),
    .ch0PosToNegRef(ch0PosToNegRef), .ch0NegIsAn1(ch0NegIsAn1),
    .sampleIsB(sampleIsB), .pinDigital(pinDigital));

  adcsel_regs #(.NUM_INPUTS(16), .IS_SECOND(1'b1)) uut2 (
    .sys_clk(sys_clk), .rst(rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(), .s_axi_bresp(bResp2),
    .s_axi_bvalid(), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(), .s_axi_rdata(rData2), .s_axi_rresp(),
    .s_axi_rvalid(), .s_axi_rready(rReady),
    .sampleDone(sampleDone), .peerPinDigital(ownLow),
    .ownPinDigitalLow(), .ch0PosSel(ch0PosSel2),
    .ch0PosToNegRef(), .ch0NegIsAn1(), .sampleIsB(), .pinDigital());

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic axiWrite(input logic [7:0] a, input logic [15:0] d,
                          input logic [3:0] s);
    @(posedge sys_clk);
    awAddr  <= a;
    wData   <= {16'h0000, d};
    wStrb   <= s;
    awValid <= 1'b1;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
    end while (!bValid);
    lastB  = bResp;
    lastB2 = bResp2;
    bReady <= 1'b0;
  endtask

  task automatic axiRead(input logic [7:0] a);
    @(posedge sys_clk);
    arAddr  <= a;
    arValid <= 1'b1;
    rReady  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arValid && arReady) arValid <= 1'b0;
    end while (!rValid);
    lastR  = rData;
    lastR2 = rData2;
    lastRr = rResp;
    rReady <= 1'b0;
  endtask

  task automatic pulse;
    @(posedge sys_clk);
    sampleDone <= 1'b1;
    @(posedge sys_clk);
    sampleDone <= 1'b0;
    tick(2);
  endtask

  // ==========================================================
  // Scenarios
  task automatic testReset;
    for (int i = 0; i < 6; i++) begin
      axiRead(8'(i * 4));
      check("reset value", lastR, 32'h00000000);
    end
    check("reset outputs", {24'h000000, ch0PosSel, ch0NegIsAn1,
          sampleIsB, ch0PosToNegRef}, 32'h00000000);
    check("reset pin mode", pinDigital, 32'h00000000);
  endtask

  task automatic testCh0;
    axiWrite(OFS_CH0_SEL, 16'hffff, 4'hf);
    axiRead(OFS_CH0_SEL);
    check("ch0 readback", lastR, 32'h00009f9f);
    check("second ch0 readback", lastR2, 32'h00008f8f);
    tick(2);
    check("pos select", 32'(ch0PosSel), 32'h0000001f);
    check("neg is input 1", 32'(ch0NegIsAn1), 32'h1);
    check("no pin flag", 32'(ch0PosToNegRef), 32'h1);
    check("second pos select", 32'(ch0PosSel2), 32'h0f);
    axiWrite(OFS_CH0_SEL, 16'h0000, 4'h1);
    axiRead(OFS_CH0_SEL);
    check("ch0 low lane", lastR, 32'h00009f00);
    tick(2);
    check("neg is reference", 32'(ch0NegIsAn1), 32'h0);
    check("pos select zero", 32'(ch0PosSel), 32'h0);
  endtask

  task automatic testAlt;
    axiWrite(OFS_CH0_SEL, 16'h8a15, 4'hf);
    axiWrite(OFS_CTRL, 16'h0002, 4'hf);
    tick(2);
    check("alt first A", 32'(sampleIsB), 32'h0);
    check("A pos", 32'(ch0PosSel), 32'h15);
    pulse();
    check("alt then B", 32'(sampleIsB), 32'h1);
    check("B pos", 32'(ch0PosSel), 32'h0a);
    check("B neg", 32'(ch0NegIsAn1), 32'h1);
    pulse();
    check("alt back A", 32'(sampleIsB), 32'h0);
    check("A neg", 32'(ch0NegIsAn1), 32'h0);
    axiWrite(OFS_CTRL, 16'h0000, 4'hf);
    pulse();
    check("no alt stays A", 32'(sampleIsB), 32'h0);
  endtask

  task automatic testScan;
    logic [4:0] seq [5];
    seq = '{5'd1, 5'd2, 5'd16, 5'd24, 5'd1};
    axiWrite(OFS_SCAN_LO, 16'h0006, 4'hf);
    axiWrite(OFS_SCAN_HI, 16'h0101, 4'hf);
    axiWrite(OFS_CTRL, 16'h0001, 4'hf);
    tick(2);
    for (int k = 0; k < 5; k++) begin
      check("scan pos", 32'(ch0PosSel),
            32'(seq[k]));
      check("scan no pin", 32'(ch0PosToNegRef),
            32'(seq[k] >= 5'(NIN)));
      pulse();
    end
    axiWrite(OFS_SCAN_HI, 16'hffff, 4'hf);
    axiRead(OFS_SCAN_HI);
    check("scan high writable", lastR, 32'h0000ffff);
    axiRead(OFS_SCAN_LO);
    check("scan low readback", lastR, 32'h00000006);
    axiWrite(OFS_CTRL, 16'h0000, 4'hf);
  endtask

  task automatic testPins;
    @(posedge sys_clk);
    peerPin <= 16'h0003;
    axiWrite(OFS_PINCFG_LO, 16'h00f0, 4'hf);
    axiWrite(OFS_PINCFG_HI, 16'hffff, 4'hf);
    axiRead(OFS_PINCFG_HI);
    check("pin high readback", lastR, 32'h0000ffff);
    tick(2);
    check("pin modes", pinDigital,
          32'h00ff00f3);
    check("own low to peer", 32'(ownLow), 32'h00f0);
    axiWrite(OFS_CTRL, 16'h0004, 4'hf);
    tick(2);
    check("module off", pinDigital, 32'h00ffffff);
    axiRead(OFS_PINCFG_LO);
    check("pin low kept", lastR, 32'h000000f0);
    axiWrite(OFS_CTRL, 16'h0000, 4'hf);
    tick(2);
    check("module on", pinDigital, 32'h00ff00f3);
  endtask

  task automatic testBus;
    axiWrite(8'h18, 16'h1234, 4'hf);
    check("unmapped write", 32'(lastB), 32'(RESP_SLVERR));
    axiRead(8'h18);
    check("unmapped read data", lastR, 32'h00000000);
    check("unmapped read resp", 32'(lastRr), 32'(RESP_SLVERR));
    axiWrite(OFS_PINCFG_HI, 16'h1234, 4'hf);
    check("first high pin write", 32'(lastB), 32'(RESP_OKAY));
    check("second high pin write", 32'(lastB2), 32'(RESP_SLVERR));
    axiRead(OFS_PINCFG_HI);
    check("second high pin read", lastR2, 32'h00000000);
    check("first high pin read", lastR, 32'h00001234);
  endtask

  // ==========================================================
  // Verdict, watchdog and main sequence
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #(20 * 20000);
    fails++;
    give_verdict();
  end

  initial begin
    tick(6);
    rst <= 1'b0;
    testReset();
    testCh0();
    testAlt();
    testScan();
    testPins();
    testBus();
    // Reset again after every register was written
    @(posedge sys_clk);
    peerPin <= 16'h0000;
    rst     <= 1'b1;
    tick(2);
    rst     <= 1'b0;
    testReset();
    give_verdict();
  end

endmodule // adcsel_regs_tb
